// ===== verilog/vtc_params.svh
// Purpose: Constants for the output-voltage target command logic.
// Assumes: Linear voltage format, exponents -12 to -4.
// Notes:   Internal voltages use a fixed exponent of -12.
`ifndef VTC_PARAMS_SVH
`define VTC_PARAMS_SVH

`define VTC_CODE_MODE     8'h20
`define VTC_CODE_CMD      8'h21
`define VTC_CODE_TRIM     8'h22
`define VTC_CODE_MAX      8'h24

`define VTC_MODE_REL_BIT  7
`define VTC_MODE_FMT_HI   6
`define VTC_MODE_FMT_LO   5
`define VTC_MODE_EXP_HI   4
`define VTC_MODE_FMT_LIN  2'h0
`define VTC_EXP_BIAS      5'h0C
`define VTC_EXP_OFF_MAX   5'h08

// Scale-loop ranges at exponent -12, rounded down to whole steps
`define VTC_HW_MAX_S1000  28'sh0000B33
`define VTC_HW_MAX_S0500  28'sh0001666
`define VTC_HW_MAX_S0250  28'sh0002CCC
`define VTC_HW_MAX_S0125  28'sh0006000

`define VTC_BKP_MAX       28'sh000007F
`define VTC_BKP_MIN       (-28'sh0000080)

`define VTC_CLK_NS        5
`define VTC_TICK_NS       1000
`define VTC_TICK_CYC      8'((`VTC_TICK_NS) / (`VTC_CLK_NS))

`endif

// ===== verilog/vtc_pkg.sv
// Purpose: Shared types for the output-voltage target command logic.
// Assumes: Constants live in vtc_params.svh.
// Notes:   Wide type holds exponent -12 values with sign and headroom.
`default_nettype none
package vtc_pkg;
  typedef logic        [15:0] vtc_word_type;
  typedef logic signed [27:0] vtc_wide_type;
  typedef enum logic [1:0] {
    VTC_LINK_IDLE = 2'b01,
    VTC_LINK_WAIT = 2'b10
  } vtc_link_state_type;
endpackage
`default_nettype wire

// ===== verilog/vtc_cmd_if.sv
// Purpose: Command crossing between link and core clock domains.
// Assumes: Toggle handshake; payload held stable while a toggle is open.
// Notes:   No clock of its own; each end samples with its own clock.
`timescale 1ns/10ps
`default_nettype none
interface vtc_cmd_if;
  logic                 req_tgl;
  logic                 write;
  logic [7:0]           code;
  vtc_pkg::vtc_word_type wdata;
  logic                 ack_tgl;
  vtc_pkg::vtc_word_type rdata;
  logic                 rerr;
  modport link (output req_tgl, write, code, wdata,
                input  ack_tgl, rdata, rerr);
  modport core (input  req_tgl, write, code, wdata,
                output ack_tgl, rdata, rerr);
endinterface
`default_nettype wire

// ===== verilog/vtc_link_port.sv
// Purpose: Host word-command port on the link clock.
// Assumes: Host holds valid until ready; one command in flight.
// Notes:   Ack passes three flops; it counts once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none
module vtc_link_port (
  input  wire logic                  link_clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  cmd_valid_in,
  input  wire logic                  cmd_write_in,
  input  wire logic [7:0]            cmd_code_in,
  input  wire vtc_pkg::vtc_word_type cmd_wdata_in,
  output logic                       cmd_ready_out,
  output logic                       rsp_valid_out,
  output vtc_pkg::vtc_word_type      rsp_data_out,
  output logic                       rsp_error_out,
  vtc_cmd_if.link                    bus_if
);
  import vtc_pkg::*;
  vtc_link_state_type st_q, st_d;
  logic [2:0]   ack_s_q;
  logic         ack_st_q, ack_st_d, req_q, req_d, wr_q, wr_d;
  logic         rv_q, rv_d, re_q, re_d;
  logic [7:0]   code_q, code_d;
  vtc_word_type wd_q, wd_d, rd_q, rd_d;

  always_comb begin
    st_d = st_q; req_d = req_q; wr_d = wr_q; code_d = code_q;
    wd_d = wd_q; rd_d = rd_q; re_d = re_q; rv_d = 1'b0;
    ack_st_d = (ack_s_q[1] == ack_s_q[2]) ? ack_s_q[2] : ack_st_q;
    case (st_q)
      VTC_LINK_IDLE: if (cmd_valid_in) begin
        wr_d = cmd_write_in; code_d = cmd_code_in; wd_d = cmd_wdata_in;
        req_d = ~req_q; st_d = VTC_LINK_WAIT;
      end
      VTC_LINK_WAIT: if (ack_st_q == req_q) begin
        rv_d = 1'b1; rd_d = bus_if.rdata; re_d = bus_if.rerr;
        st_d = VTC_LINK_IDLE;
      end
      default: st_d = VTC_LINK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_q <= VTC_LINK_IDLE; ack_s_q <= 3'h0; ack_st_q <= 1'b0;
      req_q <= 1'b0; wr_q <= 1'b0; code_q <= 8'h00; wd_q <= 16'h0000;
      rd_q <= 16'h0000; re_q <= 1'b0; rv_q <= 1'b0;
    end else begin
      st_q <= st_d; ack_s_q <= {ack_s_q[1:0], bus_if.ack_tgl};
      ack_st_q <= ack_st_d; req_q <= req_d; wr_q <= wr_d;
      code_q <= code_d; wd_q <= wd_d; rd_q <= rd_d; re_q <= re_d;
      rv_q <= rv_d;
    end
  end

  assign cmd_ready_out  = (st_q == VTC_LINK_IDLE);
  assign rsp_valid_out  = rv_q;
  assign rsp_data_out   = rd_q;
  assign rsp_error_out  = re_q;
  assign bus_if.req_tgl = req_q;
  assign bus_if.write   = wr_q;
  assign bus_if.code    = code_q;
  assign bus_if.wdata   = wd_q;

  a_link_one_flight: assert property (@(posedge link_clk_in)
    disable iff (!arst_n_in)
    (st_q == VTC_LINK_WAIT) |-> !cmd_ready_out &&
      ($past(st_q) != VTC_LINK_WAIT || $stable(wd_q))) // RQ3
    else $error("link payload moved while a command was open");
  c_link_rsp: cover property (@(posedge link_clk_in)
    disable iff (!arst_n_in) rsp_valid_out && !rsp_error_out);
endmodule
`default_nettype wire

// ===== verilog/vtc_slew.sv
// Purpose: Moves the reference toward the target at a bounded rate.
// Assumes: Step is per microsecond in exponent -12 units.
// Notes:   A zero step would freeze the output, so it acts as one.
`timescale 1ns/10ps
`default_nettype none
`include "vtc_params.svh"
module vtc_slew (
  input  wire logic                  core_clk_in,
  input  wire logic                  arst_n_in,
  input  wire vtc_pkg::vtc_word_type target_in,
  input  wire vtc_pkg::vtc_word_type step_in,
  output vtc_pkg::vtc_word_type      ref_out,
  output logic                       settled_out
);
  import vtc_pkg::*;
  logic [7:0]   cnt_q, cnt_d;
  vtc_word_type ref_q, ref_d, step, diff;
  logic         tick;

  always_comb begin
    tick  = (cnt_q == `VTC_TICK_CYC - 8'h01);
    cnt_d = tick ? 8'h00 : cnt_q + 8'h01;
    step  = (step_in == 16'h0000) ? 16'h0001 : step_in;
    diff  = (target_in > ref_q) ? target_in - ref_q : ref_q - target_in;
    ref_d = ref_q;
    if (tick && diff != 16'h0000) begin
      if (target_in > ref_q) begin
        ref_d = ref_q + ((diff < step) ? diff : step); // RQ4
      end else begin
        ref_d = ref_q - ((diff < step) ? diff : step); // RQ4
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q <= 8'h00; ref_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_d; ref_q <= ref_d;
    end
  end

  assign ref_out     = ref_q;
  assign settled_out = (ref_q == target_in);

  a_slew_no_step: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    !tick |=> $stable(ref_q)) // RQ4
    else $error("reference moved between ticks");
  a_slew_step_size: assert property (@(posedge core_clk_in)
    disable iff (!arst_n_in)
    (tick && step_in != 16'h0000 && $stable(step_in)) |=>
      ((ref_q >= $past(ref_q)) ? ref_q - $past(ref_q)
                               : $past(ref_q) - ref_q) <= step_in) // RQ4
    else $error("reference moved by more than one step");
  c_slew_settle: cover property (@(posedge core_clk_in)
    disable iff (!arst_n_in) !settled_out ##1 settled_out);
endmodule
`default_nettype wire

// ===== verilog/vtc_target_core.sv
// Purpose: Output-voltage target registers, limits and boot value.
// Assumes: Host commands arrive on the link clock; rest on core clock.
// Notes:   Stored words follow the mode exponent; math uses exponent -12.
`timescale 1ns/10ps
`default_nettype none
`include "vtc_params.svh"
// Function
// (RQ1) Mode rewrite converts stored voltage words
// (RQ2) Writes decoded with mode then in force
// (RQ3) Commanded voltage word at 21h, read/write
// (RQ4) Reference slews to target at transition rate
// (RQ5) Reset-pin assertion restores boot voltage
// (RQ6) Default from memory or select pin
// (RQ7) Boot voltage kept apart from command
// (RQ8) Fault option reverts command to boot
// (RQ9) Out-of-limit sum clamps, warns, alerts
// (RQ10) Signed trim at 22h added to command
// (RQ11) Trim backup is eight bits, exponent -12
// (RQ12) Hardware ceiling clamps without warning
// (RQ13) Valid range follows loop scale factor
// (RQ14) Oversized trim write flagged invalid data
// (RQ15) Ceiling at 24h caps every target; a floor above it wins when the sum is not over the ceiling
// (RQ16) Over-ceiling target slews to ceiling, warns
// (RQ17) Ceiling below target gives same response
// (RQ18) Mode byte: relative, fixed format, exponent
// (RQ19) Sum recomputed and limited on change
module vtc_target_core (
  input  wire logic                  core_clk_in,
  input  wire logic                  arst_n_in,
  input  wire logic                  link_clk_in,
  input  wire logic                  link_cmd_valid_in,
  input  wire logic                  link_cmd_write_in,
  input  wire logic [7:0]            link_cmd_code_in,
  input  wire vtc_pkg::vtc_word_type link_cmd_wdata_in,
  output logic                       link_cmd_ready_out,
  output logic                       link_rsp_valid_out,
  output vtc_pkg::vtc_word_type      link_rsp_data_out,
  output logic                       link_rsp_error_out,
  input  wire logic                  conversion_enable_in,
  input  wire logic                  default_source_select_in,
  input  wire logic                  fault_revert_option_in,
  input  wire logic                  reset_pin_mode_in,
  input  wire logic                  power_good_or_reset_pin_n_in,
  input  wire vtc_pkg::vtc_word_type voltage_select_pin_value_in,
  input  wire vtc_pkg::vtc_word_type nvm_command_in,
  input  wire logic [7:0]            nvm_trim_in,
  input  wire logic [7:0]            nvm_mode_in,
  input  wire vtc_pkg::vtc_word_type nvm_ceiling_in,
  input  wire logic                  restore_all_in,
  input  wire logic                  fault_shutdown_in,
  input  wire vtc_pkg::vtc_word_type floor_limit_in,
  input  wire logic [1:0]            loop_scale_sel_in,
  input  wire vtc_pkg::vtc_word_type transition_step_in,
  input  wire logic                  status_clear_in,
  output vtc_pkg::vtc_word_type      reference_out,
  output logic                       reference_settled_out,
  output vtc_pkg::vtc_word_type      target_out,
  output vtc_pkg::vtc_word_type      boot_voltage_out,
  output logic [7:0]                 nvm_trim_backup_out,
  output logic                       max_min_warn_out,
  output logic                       invalid_data_out,
  output logic                       host_alert_out
);
  import vtc_pkg::*;

  vtc_cmd_if bus_if ();

  vtc_link_port u_link (
    .link_clk_in   (link_clk_in),
    .arst_n_in     (arst_n_in),
    .cmd_valid_in  (link_cmd_valid_in),
    .cmd_write_in  (link_cmd_write_in),
    .cmd_code_in   (link_cmd_code_in),
    .cmd_wdata_in  (link_cmd_wdata_in),
    .cmd_ready_out (link_cmd_ready_out),
    .rsp_valid_out (link_rsp_valid_out),
    .rsp_data_out  (link_rsp_data_out),
    .rsp_error_out (link_rsp_error_out),
    .bus_if        (bus_if.link)
  );

  function automatic vtc_wide_type up12(input vtc_wide_type v,
                                        input logic [4:0]   off);
    return v <<< off;
  endfunction

  function automatic vtc_wide_type dn12(input vtc_wide_type v,
                                        input logic [4:0]   off);
    return v >>> off;
  endfunction

  function automatic vtc_wide_type zx(input vtc_word_type w);
    return vtc_wide_type'({12'h000, w});
  endfunction

  function automatic vtc_wide_type sx(input vtc_word_type w);
    return vtc_wide_type'(signed'(w));
  endfunction

  // Re-express a stored word under a new exponent
  function automatic vtc_word_type conv(input vtc_wide_type v,
                                        input logic [4:0]   old_off,
                                        input logic [4:0]   new_off);
    vtc_wide_type t;
    t = dn12(up12(v, old_off), new_off);
    return t[15:0];
  endfunction

  logic [2:0]   req_s_q, pin_s_q;
  logic         req_st_q, req_st_d, last_q, last_d, ack_q, ack_d;
  logic         pin_st_q, pin_st_d, load_q, load_d, chg_q, chg_d;
  logic         rel_q, rel_d, rerr_q, rerr_d;
  logic         warn_q, warn_d, inval_q, inval_d, alert_q, alert_d;
  logic [4:0]   exp_q, exp_d, off_q, new_off, nvm_off;
  vtc_word_type cmd_q, cmd_d, trim_q, trim_d, max_q, max_d;
  vtc_word_type boot_q, boot_d, rdata_q, rdata_d, tgt_q, tgt_d;
  vtc_word_type boot_src, wd;
  logic [7:0]   bkp_q, bkp_d;
  vtc_wide_type sum, max_e, min_e, hw_max, lim, trim_e, trim_abs, bkp_e;
  logic         go, over, under, inval_set;

  always_comb begin
    off_q = exp_q + `VTC_EXP_BIAS;
    case (loop_scale_sel_in)
      2'h0:    hw_max = `VTC_HW_MAX_S1000; // RQ13
      2'h1:    hw_max = `VTC_HW_MAX_S0500; // RQ13
      2'h2:    hw_max = `VTC_HW_MAX_S0250; // RQ13
      default: hw_max = `VTC_HW_MAX_S0125; // RQ13
    endcase
    sum   = up12(zx(cmd_q), off_q) + up12(sx(trim_q), off_q); // RQ10 RQ19
    max_e = up12(zx(max_q), off_q);
    min_e = up12(zx(floor_limit_in), off_q);
    over  = (sum > max_e); // RQ15 RQ17
    under = !over && (sum < min_e); // RQ9
    lim   = over ? max_e : (under ? min_e : sum); // RQ9 RQ16
    if (lim > hw_max) begin
      lim = hw_max; // RQ12
    end
    if (lim < 28'sh0000000) begin
      lim = 28'sh0000000;
    end
    tgt_d = lim[15:0];
    // Backup copy always at exponent -12, saturated to one byte
    bkp_e = up12(sx(trim_q), off_q);
    if (bkp_e > `VTC_BKP_MAX) begin
      bkp_e = `VTC_BKP_MAX; // RQ11
    end else if (bkp_e < `VTC_BKP_MIN) begin
      bkp_e = `VTC_BKP_MIN; // RQ11
    end
    bkp_d = bkp_e[7:0];
  end

  always_comb begin
    req_st_d = (req_s_q[1] == req_s_q[2]) ? req_s_q[2] : req_st_q;
    pin_st_d = (pin_s_q[1] == pin_s_q[2]) ? pin_s_q[2] : pin_st_q;
    last_d = last_q; ack_d = ack_q; rerr_d = rerr_q; rdata_d = rdata_q;
    rel_d = rel_q; exp_d = exp_q; cmd_d = cmd_q; trim_d = trim_q;
    max_d = max_q; boot_d = boot_q; load_d = load_q;
    chg_d = 1'b0; inval_set = 1'b0;
    wd = bus_if.wdata;
    new_off = wd[`VTC_MODE_EXP_HI:0] + `VTC_EXP_BIAS;
    nvm_off = nvm_mode_in[`VTC_MODE_EXP_HI:0] + `VTC_EXP_BIAS;
    trim_e = up12(sx(wd), off_q); // RQ2
    trim_abs = (trim_e < 28'sh0000000) ? -trim_e : trim_e;
    boot_src = default_source_select_in ? voltage_select_pin_value_in
                                        : nvm_command_in; // RQ6
    go = (req_st_q != last_q);
    if (go) begin
      last_d = req_st_q;
      ack_d = ~ack_q; // RQ3
      rerr_d = 1'b0;
      case (bus_if.code)
        `VTC_CODE_MODE: begin
          rdata_d = {8'h00, rel_q, `VTC_MODE_FMT_LIN, exp_q}; // RQ18
          if (bus_if.write) begin
            // Exponent is frozen while converting, like the hardware DAC
            if (conversion_enable_in || new_off > `VTC_EXP_OFF_MAX ||
                wd[`VTC_MODE_FMT_HI:`VTC_MODE_FMT_LO] !=
                `VTC_MODE_FMT_LIN) begin
              inval_set = 1'b1; // RQ18
            end else begin
              rel_d  = wd[`VTC_MODE_REL_BIT];
              exp_d  = wd[`VTC_MODE_EXP_HI:0];
              cmd_d  = conv(zx(cmd_q), off_q, new_off); // RQ1
              trim_d = conv(sx(trim_q), off_q, new_off); // RQ1
              max_d  = conv(zx(max_q), off_q, new_off); // RQ1
              boot_d = conv(zx(boot_q), off_q, new_off); // RQ1
              chg_d  = 1'b1;
            end
          end
        end
        `VTC_CODE_CMD: begin
          rdata_d = cmd_q;
          if (bus_if.write) begin
            cmd_d = wd; // RQ3 RQ7
            chg_d = 1'b1;
          end
        end
        `VTC_CODE_TRIM: begin
          rdata_d = trim_q;
          if (bus_if.write) begin
            if (trim_abs > hw_max) begin
              inval_set = 1'b1; // RQ14
            end else begin
              trim_d = wd; // RQ10
              chg_d  = 1'b1;
            end
          end
        end
        `VTC_CODE_MAX: begin
          rdata_d = max_q;
          if (bus_if.write) begin
            max_d = wd; // RQ15 RQ17
            chg_d = 1'b1;
          end
        end
        default: begin
          rdata_d = 16'h0000;
          rerr_d  = 1'b1;
        end
      endcase
    end
    if ((reset_pin_mode_in && !pin_st_q) ||
        (fault_shutdown_in && fault_revert_option_in)) begin
      cmd_d = boot_q; // RQ5 RQ8
      chg_d = 1'b1;
    end
    if (load_q || restore_all_in) begin
      load_d = 1'b0;
      rel_d  = nvm_mode_in[`VTC_MODE_REL_BIT];
      exp_d  = nvm_mode_in[`VTC_MODE_EXP_HI:0];
      boot_d = boot_src; // RQ6 RQ7
      cmd_d  = boot_src; // RQ6
      trim_d = conv(sx({{8{nvm_trim_in[7]}}, nvm_trim_in}), 5'h00,
                    nvm_off); // RQ11
      max_d  = nvm_ceiling_in;
      chg_d  = 1'b1;
    end
    // A new event wins over a clear in the same cycle
    warn_d  = (warn_q & ~status_clear_in) | (chg_q & (over | under)); // RQ9
    inval_d = (inval_q & ~status_clear_in) | inval_set; // RQ14
    alert_d = warn_d | inval_d; // RQ9 RQ16
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      req_s_q <= 3'h0; pin_s_q <= 3'h7; req_st_q <= 1'b0;
      pin_st_q <= 1'b1; last_q <= 1'b0; ack_q <= 1'b0; rerr_q <= 1'b0;
      rdata_q <= 16'h0000; rel_q <= 1'b0; exp_q <= 5'h00;
      cmd_q <= 16'h0000; trim_q <= 16'h0000; max_q <= 16'h0000;
      boot_q <= 16'h0000; load_q <= 1'b1; chg_q <= 1'b0;
      warn_q <= 1'b0; inval_q <= 1'b0; alert_q <= 1'b0;
      tgt_q <= 16'h0000; bkp_q <= 8'h00;
    end else begin
      req_s_q <= {req_s_q[1:0], bus_if.req_tgl};
      pin_s_q <= {pin_s_q[1:0], power_good_or_reset_pin_n_in};
      req_st_q <= req_st_d; pin_st_q <= pin_st_d; last_q <= last_d;
      ack_q <= ack_d; rerr_q <= rerr_d; rdata_q <= rdata_d;
      rel_q <= rel_d; exp_q <= exp_d; cmd_q <= cmd_d; trim_q <= trim_d;
      max_q <= max_d; boot_q <= boot_d; load_q <= load_d;
      chg_q <= chg_d; warn_q <= warn_d; inval_q <= inval_d;
      alert_q <= alert_d; tgt_q <= tgt_d; bkp_q <= bkp_d;
    end
  end

  assign bus_if.ack_tgl = ack_q;
  assign bus_if.rdata   = rdata_q;
  assign bus_if.rerr    = rerr_q;

  vtc_slew u_slew (
    .core_clk_in (core_clk_in),
    .arst_n_in   (arst_n_in),
    .target_in   (tgt_q),
    .step_in     (transition_step_in),
    .ref_out     (reference_out),
    .settled_out (reference_settled_out)
  );

  assign target_out          = tgt_q;
  assign boot_voltage_out    = boot_q;
  assign nvm_trim_backup_out = bkp_q;
  assign max_min_warn_out    = warn_q;
  assign invalid_data_out    = inval_q;
  assign host_alert_out      = alert_q;

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!arst_n_in);

  a_ceiling_caps_target: assert property ( // RQ15
    (min_e <= max_e && max_e >= 28'sh0000000) |=>
      (zx(tgt_q) <= $past(max_e)))
    else $error("target above the ceiling");
  a_hw_limit_holds: assert property ( // RQ12
    1'b1 |=> (zx(tgt_q) <= $past(hw_max)))
    else $error("target above the hardware range");
  a_warn_on_limit: assert property ( // RQ9
    (chg_q && (over || under)) |=> warn_q && alert_q)
    else $error("limit warning or alert missing");
  a_quiet_in_range: assert property ( // RQ12
    (chg_q && !over && !under && !warn_q && !status_clear_in) |=>
      !warn_q)
    else $error("warning raised for an in-range target");
  a_pin_boot_load: assert property ( // RQ5
    (reset_pin_mode_in && !pin_st_q && !load_q && !restore_all_in) |=>
      (cmd_q == $past(boot_q)))
    else $error("reset pin did not restore the boot voltage");
  a_fault_revert: assert property ( // RQ8
    (fault_shutdown_in && fault_revert_option_in && !load_q &&
     !restore_all_in) |=> (cmd_q == $past(boot_q)))
    else $error("fault revert did not restore the boot voltage");
  a_boot_source: assert property ( // RQ6
    (load_q || restore_all_in) |=> (boot_q == $past(boot_src)))
    else $error("boot voltage taken from the wrong source");
  a_boot_kept: assert property ( // RQ7
    (!load_q && !restore_all_in && !(go && bus_if.code ==
     `VTC_CODE_MODE)) |=> $stable(boot_q))
    else $error("boot voltage changed by a command write");
  a_ack_per_cmd: assert property ( // RQ3
    go |=> (ack_q != $past(ack_q)) ##1 $stable(ack_q))
    else $error("command not acknowledged exactly once");

  c_pin_reset: cover property (reset_pin_mode_in && !pin_st_q);
  c_mode_change: cover property (go && bus_if.write &&
    bus_if.code == `VTC_CODE_MODE && !inval_set);
  c_trim_invalid: cover property (inval_set &&
    bus_if.code == `VTC_CODE_TRIM);
endmodule
`default_nettype wire

// ===== bench/vtc_host_model.sv
// Purpose: Host controller model issuing word commands on the link port.
// Assumes: Link clock runs during reset and around each command only.
// Notes:   Released lines show inverted data so stale values cannot pass.
`timescale 1ns/10ps
`default_nettype none
module vtc_host_model (
  input  wire logic                  ready_in,
  input  wire logic                  rsp_valid_in,
  input  wire vtc_pkg::vtc_word_type rsp_data_in,
  input  wire logic                  rsp_error_in,
  output logic                       link_clk_out,
  output logic                       valid_out,
  output logic                       write_out,
  output logic [7:0]                 code_out,
  output vtc_pkg::vtc_word_type      wdata_out
);
  import vtc_pkg::*;
  logic run = 1'b1;
  initial begin
    link_clk_out = 1'b0;
    valid_out = 1'b0;
    write_out = 1'b0;
    code_out = 8'h00;
    wdata_out = 16'h0000;
    #1.3;
    forever #62.5 link_clk_out = run ? ~link_clk_out : 1'b0;
  end
  task automatic xfer(input logic w, input logic [7:0] c,
                      input vtc_word_type d, output vtc_word_type rd,
                      output logic err);
    int n;
    n = 0;
    run = 1'b1;
    @(posedge link_clk_out);
    #1;
    valid_out = 1'b1;
    write_out = w;
    code_out = c;
    wdata_out = d;
    while (ready_in !== 1'b1) begin
      @(posedge link_clk_out);
      #1;
    end
    @(posedge link_clk_out);
    valid_out <= 1'b0;
    code_out <= ~c;
    wdata_out <= ~d;
    do begin
      @(posedge link_clk_out);
      #1;
      n++;
    end while (rsp_valid_in !== 1'b1 && n < 20);
    rd = rsp_data_in;
    err = (n < 20) ? rsp_error_in : 1'bx;
    @(posedge link_clk_out);
    #1;
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bench/vtc_target_core_tb.sv
// Purpose: Self-checking bench for the voltage target command logic.
// Assumes: Mode exponent -12 from memory, floor at zero.
// Notes:   Reset also waits two link edges so both domains clear.
`timescale 1ns/10ps
`default_nettype none
module vtc_target_core_tb;
  import vtc_pkg::*;
  logic         core_clk = 1'b0, arst_n = 1'b0;
  logic         conv, src, fopt, pmode, pin_n, rest, flt, clr, lclk;
  logic         vld, wr, rdy, rvld, rerr, setl, warn, inval, alert, e;
  logic [1:0]   scale;
  logic [7:0]   code, bkp;
  vtc_word_type wdata, rdat, rd, v, ref_v, tgt, boot, flr, stp;
  int           err_count = 0, checks = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  vtc_host_model u_vtc_host_model (.ready_in(rdy), .rsp_valid_in(rvld),
    .rsp_data_in(rdat), .rsp_error_in(rerr), .link_clk_out(lclk),
    .valid_out(vld), .write_out(wr), .code_out(code), .wdata_out(wdata));
  vtc_target_core u_vtc_target_core (.core_clk_in(core_clk),
    .arst_n_in(arst_n), .link_clk_in(lclk), .link_cmd_valid_in(vld),
    .link_cmd_write_in(wr), .link_cmd_code_in(code),
    .link_cmd_wdata_in(wdata), .link_cmd_ready_out(rdy),
    .link_rsp_valid_out(rvld), .link_rsp_data_out(rdat),
    .link_rsp_error_out(rerr), .conversion_enable_in(conv),
    .default_source_select_in(src), .fault_revert_option_in(fopt),
    .reset_pin_mode_in(pmode), .power_good_or_reset_pin_n_in(pin_n),
    .voltage_select_pin_value_in(16'h0300), .nvm_command_in(16'h0400),
    .nvm_trim_in(8'h00), .nvm_mode_in(8'h14), .nvm_ceiling_in(16'h5000),
    .restore_all_in(rest), .fault_shutdown_in(flt),
    .floor_limit_in(flr), .loop_scale_sel_in(scale),
    .transition_step_in(stp), .status_clear_in(clr),
    .reference_out(ref_v), .reference_settled_out(setl),
    .target_out(tgt), .boot_voltage_out(boot),
    .nvm_trim_backup_out(bkp), .max_min_warn_out(warn),
    .invalid_data_out(inval), .host_alert_out(alert));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
    u_vtc_host_model.xfer(w, c, d, rd, e);
    if (e === 1'bx) err_count++;
  endtask
  task automatic clear_flags;
    @(posedge core_clk) clr <= 1'b1;
    @(posedge core_clk) clr <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  // Clamp to ceiling, then to the hardware range of the loop scale
  function automatic logic [15:0] exp_tgt(input int s, input int mx,
                                          input int hw);
    if (s > mx) s = mx;
    if (s > hw) s = hw;
    return 16'(s);
  endfunction
  task automatic print_verdict;
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    {conv, src, fopt, pmode, rest, flt, clr} = 7'h00;
    pin_n = 1'b1;
    flr = 16'h0000;
    stp = 16'h0100;
    scale = 2'h3;
    v = 16'($urandom(32'h356ece07));
    repeat (2) @(posedge lclk);
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(boot, 16'h0400);
    cmd(0, 8'h21, 0); check(rd, 16'h0400);
    cmd(0, 8'h23, 0); check({e, rd[14:0]}, 16'h8000);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 16'h0000 : 16'($urandom_range(16'h4000));
      cmd(1, 8'h21, v); cmd(0, 8'h21, 0); check(rd, v);
      check(tgt, exp_tgt(int'(v), 16'h5000, 24576));
    end
    check(boot, 16'h0400);
    cmd(1, 8'h21, 16'h1000); cmd(1, 8'h22, 16'hFF00);
    check(tgt, 16'h0F00);
    check({8'h00, bkp}, 16'h0080);
    cmd(1, 8'h24, 16'h0800); check(tgt, 16'h0800);
    check({14'h0, warn, alert}, 16'h0003);
    clear_flags();
    cmd(1, 8'h21, 16'h0A00); check({tgt[14:0], warn}, 16'h1001);
    clear_flags();
    @(posedge core_clk) scale <= 2'h0;
    cmd(1, 8'h24, 16'hFFFF); cmd(1, 8'h22, 0); cmd(1, 8'h21, 16'h1000);
    check(tgt, exp_tgt(16'h1000, 16'hFFFF, 2867));
    check({15'h0, warn}, 16'h0000);
    flr <= 16'h0800;
    cmd(1, 8'h21, 16'h0400); check({tgt[14:0], warn}, 16'h1001);
    flr <= 16'h0000;
    cmd(1, 8'h22, 16'h0C00); cmd(0, 8'h22, 0);
    check({rd[14:0], inval}, 16'h0001);
    clear_flags();
    cmd(1, 8'h21, 16'h0100); check({15'h0, setl}, 16'h0000);
    for (int i = 0; i < 5000 && setl !== 1'b1; i++) @(posedge core_clk);
    check(ref_v, 16'h0100);
    fopt <= 1'b1;
    @(posedge core_clk) flt <= 1'b1;
    @(posedge core_clk) flt <= 1'b0;
    cmd(0, 8'h21, 0); check(rd, 16'h0400);
    fopt <= 1'b0;
    cmd(1, 8'h21, 16'h0300);
    @(posedge core_clk) flt <= 1'b1;
    @(posedge core_clk) flt <= 1'b0;
    cmd(0, 8'h21, 0); check(rd, 16'h0300);
    pmode <= 1'b1;
    @(posedge core_clk) pin_n <= 1'b0;
    repeat (8) @(posedge core_clk);
    pin_n <= 1'b1;
    cmd(0, 8'h21, 0); check(rd, 16'h0400);
    src <= 1'b1;
    @(posedge core_clk) rest <= 1'b1;
    @(posedge core_clk) rest <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(boot, 16'h0300);
    cmd(1, 8'h21, 16'h0800); cmd(1, 8'h20, 16'h0018);
    cmd(0, 8'h21, 0); check(rd, 16'h0080);
    cmd(1, 8'h21, 16'h0040); check(tgt, 16'h0400);
    cmd(1, 8'h20, 16'h0078); cmd(0, 8'h20, 0);
    check({rd[14:0], inval}, 16'h0031);
    clear_flags();
    conv <= 1'b1;
    cmd(1, 8'h20, 16'h0014); check({15'h0, inval}, 16'h0001);
    print_verdict();
  end
endmodule
`default_nettype wire
